// *** ssy_port.sv ***
// Purpose: Synchronous serial port, master or slave, APB registers.
// Assumes: link_clk_i runs freely; config changes only while disabled.
// Notes:   FIFOs live on core_clk_i, shifting on link_clk_i.
`timescale 1ns/1ps
`default_nettype none

module ssy_port (
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic        link_clk_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe_n_o,
	input  wire logic        select_framesync_pin_i,
	output logic             select_framesync_pin_o,
	output logic             select_framesync_pin_oe_n_o,
	input  wire logic        slave_to_master_data_pin_i,
	output logic             slave_to_master_data_pin_o,
	output logic             slave_to_master_data_pin_oe_n_o,
	input  wire logic        master_to_slave_data_pin_i,
	output logic             master_to_slave_data_pin_o,
	output logic             master_to_slave_data_pin_oe_n_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] ptr_inc(input logic [2:0] p);
		ptr_inc = p + 3'h1;
	endfunction

	function automatic logic [4:0] frame_len(input logic [3:0] sz);
		frame_len = (sz < 4'h3) ? ssy_pkg::FRAME_MIN : {1'b0, sz} + 5'h01;
	endfunction

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic [9:0]  ctrl;
	logic [7:0]  div;
	logic [15:0] tx_mem [8];
	logic [15:0] rx_mem [8];
	logic [2:0]  tx_wp, tx_rp, rx_wp, rx_rp;
	logic [3:0]  tx_cnt, rx_cnt;
	logic        rx_ovr;
	logic [15:0] tx_word;
	logic        tx_req;
	logic        tx_ack_s1, tx_ack_s2;
	logic        rx_s1, rx_s2, rx_s3;
	logic        busy_s1, busy_s2;
	logic [15:0] rx_word;
	logic        rx_tgl, tx_ack, busy;

	wire         apb_done = psel_i & penable_i & pready_o;
	wire         hit_ctrl = paddr_i == ssy_pkg::ADDR_CTRL;
	wire         hit_div  = paddr_i == ssy_pkg::ADDR_DIV;
	wire         hit_data = paddr_i == ssy_pkg::ADDR_DATA;
	wire         hit_stat = paddr_i == ssy_pkg::ADDR_STAT;
	wire         mapped   = hit_ctrl | hit_div | hit_data | hit_stat;
	wire         wr_done  = apb_done & pwrite_i;
	wire         rd_done  = apb_done & ~pwrite_i;
	wire         tx_full  = tx_cnt == ssy_pkg::FIFO_DEPTH;
	wire         rx_full  = rx_cnt == ssy_pkg::FIFO_DEPTH;
	wire         tx_empty = tx_cnt == 4'h0;
	wire         rx_empty = rx_cnt == 4'h0;
	wire         ctrl_en  = ctrl[ssy_pkg::CTRL_EN];
	wire         tx_push  = wr_done & hit_data & ~tx_full;
	wire         tx_pend  = tx_req ^ tx_ack_s2;
	wire         tx_pop   = ~tx_pend & ~tx_empty & ctrl_en;
	wire         rx_new   = rx_s2 ^ rx_s3;
	wire         rx_push  = rx_new & ~rx_full;
	wire         rx_pop   = rd_done & hit_data & ~rx_empty;
	wire         ovr_clr  = wr_done & hit_stat & pwdata_i[ssy_pkg::STAT_ROVR];
	wire [31:0]  stat_word = {26'h000_0000, rx_ovr, busy_s2, rx_full,
	                          ~rx_empty, ~tx_full, tx_empty};
	wire [31:0]  next_rdata = hit_ctrl ? {22'h00_0000, ctrl} :
	                          hit_div  ? {24'h00_0000, div} :
	                          hit_data ? {16'h0000, rx_mem[rx_rp]} :
	                          hit_stat ? stat_word : 32'h0000_0000;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= psel_i & penable_i & ~pready_o;
			pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
			prdata_o  <= next_rdata;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ctrl <= ssy_pkg::CTRL_RESET;
			div  <= ssy_pkg::DIV_RESET;
		end else if (wr_done) begin
			if (hit_ctrl)
				ctrl <= pwdata_i[9:0];
			if (hit_div)
				div <= pwdata_i[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Buffers, eight frames each way
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (tx_push)
			tx_mem[tx_wp] <= pwdata_i[15:0];
		if (rx_push)
			rx_mem[rx_wp] <= rx_word;
	end

	// Overflowing writes and receptions are dropped, not stalled
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			tx_wp  <= 3'h0;
			tx_rp  <= 3'h0;
			tx_cnt <= 4'h0;
			rx_wp  <= 3'h0;
			rx_rp  <= 3'h0;
			rx_cnt <= 4'h0;
			rx_ovr <= 1'b0;
		end else begin
			if (tx_push)
				tx_wp <= ptr_inc(tx_wp);
			if (tx_pop)
				tx_rp <= ptr_inc(tx_rp);
			tx_cnt <= tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
			if (rx_push)
				rx_wp <= ptr_inc(rx_wp);
			if (rx_pop)
				rx_rp <= ptr_inc(rx_rp);
			rx_cnt <= rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};
			if (rx_new & rx_full)
				rx_ovr <= 1'b1;
			else if (ovr_clr)
				rx_ovr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Core side of the crossings
	// ----------------------------------------------------------------
	// Word is held until the link hands the toggle back
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			tx_req    <= 1'b0;
			tx_word   <= 16'h0000;
			tx_ack_s1 <= 1'b0;
			tx_ack_s2 <= 1'b0;
			rx_s1     <= 1'b0;
			rx_s2     <= 1'b0;
			rx_s3     <= 1'b0;
			busy_s1   <= 1'b0;
			busy_s2   <= 1'b0;
		end else begin
			tx_ack_s1 <= tx_ack;
			tx_ack_s2 <= tx_ack_s1;
			rx_s1     <= rx_tgl;
			rx_s2     <= rx_s1;
			rx_s3     <= rx_s2;
			busy_s1   <= busy;
			busy_s2   <= busy_s1;
			if (tx_pop) begin
				tx_word <= tx_mem[tx_rp];
				tx_req  <= ~tx_req;
			end
		end
	end

	// ----------------------------------------------------------------
	// Link domain synchronisers
	// ----------------------------------------------------------------
	logic       lrst_s1, lrst;
	logic [9:0] cfg_s1, cfg;
	logic [7:0] div_s1, ldiv;
	logic       req_s1, req_s2;
	logic       sck_s1, sck_s2, sck_s3;
	logic       sel_s1, sel_s2;
	logic       mosi_s1, mosi_s2;
	logic       miso_s1, miso_s2;

	always_ff @(posedge link_clk_i) begin
		lrst_s1 <= reset_i;
		lrst    <= lrst_s1;
		cfg_s1  <= ctrl;
		cfg     <= cfg_s1;
		div_s1  <= div;
		ldiv    <= div_s1;
		req_s1  <= tx_req;
		req_s2  <= req_s1;
		sck_s1  <= serial_clock_pin_i;
		sck_s2  <= sck_s1;
		sck_s3  <= sck_s2;
		sel_s1  <= select_framesync_pin_i;
		sel_s2  <= sel_s1;
		mosi_s1 <= master_to_slave_data_pin_i;
		mosi_s2 <= mosi_s1;
		miso_s1 <= slave_to_master_data_pin_i;
		miso_s2 <= miso_s1;
	end

	// ----------------------------------------------------------------
	// Link logic
	// ----------------------------------------------------------------
	ssy_pkg::ssy_link_state_type state;
	logic [7:0]  hc;
	logic [4:0]  bit_cnt;
	logic [15:0] tx_sh, rx_sh;
	logic        slv_act;

	wire [1:0]  cfg_fmt   = cfg[ssy_pkg::CTRL_FMT_LSB +: 2];
	wire        cfg_en    = cfg[ssy_pkg::CTRL_EN];
	wire        cfg_slave = cfg[ssy_pkg::CTRL_SLAVE];
	wire        fmt_ssi   = cfg_fmt == ssy_pkg::FMT_SSI;
	wire        cpol_eff  = (cfg_fmt == ssy_pkg::FMT_SPI) &
	                        cfg[ssy_pkg::CTRL_CPOL];
	wire        sel_lvl   = fmt_ssi;
	wire [4:0]  nbits     = frame_len(cfg[ssy_pkg::CTRL_SIZE_LSB +: 4]);
	wire        tx_have   = req_s2 ^ tx_ack;
	wire        hc_done   = hc >= ldiv;
	wire [15:0] tx_align  = 16'(tx_word << (5'h10 - nbits));
	wire [15:0] tx_next   = tx_have ? tx_align : 16'h0000;
	wire [15:0] rx_in_m   = {rx_sh[14:0], miso_s2};
	wire [15:0] rx_in_s   = {rx_sh[14:0], mosi_s2};
	wire        last_bit  = bit_cnt == nbits - 5'h01;
	wire        sck_edge  = sck_s2 ^ sck_s3;
	wire        lead      = sck_edge & (sck_s2 != cpol_eff);
	wire        trail     = sck_edge & (sck_s2 == cpol_eff);
	wire        slv_start = fmt_ssi ? sel_s2 : (sel_s2 == sel_lvl);
	wire        slv_sel   = fmt_ssi ? slv_act : (sel_s2 == sel_lvl);
	wire        slv_run   = slv_act & (bit_cnt < nbits);

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			state                           <= ssy_pkg::LNK_IDLE;
			hc                              <= 8'h00;
			bit_cnt                         <= 5'h00;
			tx_sh                           <= 16'h0000;
			rx_sh                           <= 16'h0000;
			rx_word                         <= 16'h0000;
			rx_tgl                          <= 1'b0;
			tx_ack                          <= 1'b0;
			slv_act                         <= 1'b0;
			busy                            <= 1'b0;
			serial_clock_pin_o              <= 1'b0;
			serial_clock_pin_oe_n_o         <= 1'b1;
			select_framesync_pin_o          <= 1'b1;
			select_framesync_pin_oe_n_o     <= 1'b1;
			master_to_slave_data_pin_o      <= 1'b0;
			master_to_slave_data_pin_oe_n_o <= 1'b1;
			slave_to_master_data_pin_o      <= 1'b0;
			slave_to_master_data_pin_oe_n_o <= 1'b1;
		end else if (!cfg_slave) begin
			busy                            <= state != ssy_pkg::LNK_IDLE;
			slv_act                         <= 1'b0;
			// Disabled master releases its lines
			serial_clock_pin_oe_n_o         <= ~cfg_en;
			select_framesync_pin_oe_n_o     <= ~cfg_en;
			master_to_slave_data_pin_oe_n_o <= ~cfg_en;
			slave_to_master_data_pin_oe_n_o <= 1'b1;
			hc <= hc_done ? 8'h00 : hc + 8'h01;
			unique case (state)
			ssy_pkg::LNK_IDLE: begin
				serial_clock_pin_o     <= cpol_eff;
				select_framesync_pin_o <= ~sel_lvl;
				if (cfg_en && tx_have) begin
					tx_sh                  <= tx_align;
					rx_sh                  <= 16'h0000;
					tx_ack                 <= ~tx_ack;
					hc                     <= 8'h00;
					bit_cnt                <= 5'h00;
					select_framesync_pin_o <= sel_lvl;
					state                  <= ssy_pkg::LNK_SYNC;
				end
			end
			ssy_pkg::LNK_SYNC: begin
				if (hc_done) begin
					master_to_slave_data_pin_o <= tx_sh[15];
					if (fmt_ssi)
						select_framesync_pin_o <= ~sel_lvl;
					state <= ssy_pkg::LNK_SHIFT;
				end
			end
			ssy_pkg::LNK_SHIFT: begin
				if (hc_done) begin
					serial_clock_pin_o <= ~serial_clock_pin_o;
					if (serial_clock_pin_o == cpol_eff) begin
						rx_sh <= rx_in_m;
					end else begin
						tx_sh                      <= 16'(tx_sh << 1);
						master_to_slave_data_pin_o <= tx_sh[14];
						bit_cnt                    <= bit_cnt + 5'h01;
						if (last_bit)
							state <= ssy_pkg::LNK_DONE;
					end
				end
			end
			ssy_pkg::LNK_DONE: begin
				if (hc_done) begin
					select_framesync_pin_o <= ~sel_lvl;
					rx_word                <= rx_sh;
					rx_tgl                 <= ~rx_tgl;
					state                  <= ssy_pkg::LNK_IDLE;
				end
			end
			endcase
		end else begin
			state                           <= ssy_pkg::LNK_IDLE;
			busy                            <= slv_act;
			serial_clock_pin_oe_n_o         <= 1'b1;
			select_framesync_pin_oe_n_o     <= 1'b1;
			master_to_slave_data_pin_oe_n_o <= 1'b1;
			// Released while unselected so other slaves can answer
			slave_to_master_data_pin_oe_n_o <= ~(cfg_en & slv_sel);
			slave_to_master_data_pin_o      <= tx_sh[15];
			if (!slv_act) begin
				if (cfg_en && slv_start) begin
					slv_act <= 1'b1;
					tx_sh   <= tx_next;
					rx_sh   <= 16'h0000;
					bit_cnt <= 5'h00;
					if (tx_have)
						tx_ack <= ~tx_ack;
				end
			end else if (!fmt_ssi && !slv_sel) begin
				slv_act <= 1'b0;
			end else if (lead && slv_run) begin
				rx_sh   <= rx_in_s;
				bit_cnt <= bit_cnt + 5'h01;
				if (last_bit) begin
					rx_word <= rx_in_s;
					rx_tgl  <= ~rx_tgl;
				end
			end else if (trail) begin
				if (slv_run)
					tx_sh <= 16'(tx_sh << 1);
				else if (fmt_ssi)
					slv_act <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_tx_depth_limit: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		tx_cnt <= ssy_pkg::FIFO_DEPTH && rx_cnt <= ssy_pkg::FIFO_DEPTH)
		else $error("buffer count above eight");

	a_tx_push_count: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		tx_push && !tx_pop |=> tx_cnt == $past(tx_cnt) + 4'h1)
		else $error("transmit push not counted");

	a_reset_empty: assert property (@(posedge core_clk_i)
		reset_i |=> tx_empty && rx_empty && !rx_ovr && !pready_o)
		else $error("buffers not empty after reset");

	a_rx_store: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		rx_new && !rx_full && !rx_pop |=> rx_cnt == $past(rx_cnt) + 4'h1)
		else $error("received frame not stored");

	a_sclk_idle: assert property (@(posedge link_clk_i)
		disable iff (lrst)
		!cfg_slave && state == ssy_pkg::LNK_IDLE [*2]
		|-> serial_clock_pin_o == $past(cpol_eff))
		else $error("serial clock not idle between frames");

	a_select_frame: assert property (@(posedge link_clk_i)
		disable iff (lrst)
		!cfg_slave && !fmt_ssi && $past(state == ssy_pkg::LNK_SHIFT)
		|-> select_framesync_pin_o == sel_lvl && !select_framesync_pin_oe_n_o)
		else $error("select not active during data");

	a_frame_length: assert property (@(posedge link_clk_i)
		disable iff (lrst)
		$past(state == ssy_pkg::LNK_SHIFT) && state == ssy_pkg::LNK_DONE
		|-> bit_cnt == nbits)
		else $error("frame length wrong");

	a_miso_release: assert property (@(posedge link_clk_i)
		disable iff (lrst)
		cfg_slave && !fmt_ssi && sel_s2 != sel_lvl ##1 $stable(cfg)
		|-> slave_to_master_data_pin_oe_n_o)
		else $error("unselected slave drives return line");

	a_mosi_drive: assert property (@(posedge link_clk_i)
		disable iff (lrst)
		state == ssy_pkg::LNK_SHIFT ##1 $stable(cfg)
		|-> !master_to_slave_data_pin_oe_n_o)
		else $error("master not driving forward line");

endmodule

`default_nettype wire

// *** ssy_pkg.sv ***
// Purpose: Shared constants for the synchronous serial port.
// Assumes: APB register window with 12-bit byte addresses.
// Notes:   Offsets are byte addresses of 32-bit words.
`default_nettype none

package ssy_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_DIV  = 12'h004;
	localparam logic [11:0] ADDR_DATA = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int          CTRL_W        = 10;
	localparam int          CTRL_SIZE_LSB = 0;
	localparam int          CTRL_FMT_LSB  = 4;
	localparam int          CTRL_CPOL     = 6;
	localparam int          CTRL_SLAVE    = 8;
	localparam int          CTRL_EN       = 9;
	localparam logic [9:0]  CTRL_RESET    = 10'h007;
	localparam logic [7:0]  DIV_RESET     = 8'h04;

	// Frame formats
	localparam logic [1:0]  FMT_SPI   = 2'h0;
	localparam logic [1:0]  FMT_SSI   = 2'h1;
	localparam logic [1:0]  FMT_MWIRE = 2'h2;

	// ----------------------------------------------------------------
	// Status fields
	// ----------------------------------------------------------------
	localparam int          STAT_TFE   = 0;
	localparam int          STAT_TNF   = 1;
	localparam int          STAT_RNE   = 2;
	localparam int          STAT_RFF   = 3;
	localparam int          STAT_BSY   = 4;
	localparam int          STAT_ROVR  = 5;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int          FRAME_MAX  = 16;
	localparam logic [4:0]  FRAME_MIN  = 5'h04;
	localparam logic [3:0]  FIFO_DEPTH = 4'h8;

	typedef enum logic [3:0] {
		LNK_IDLE  = 4'b0001,
		LNK_SYNC  = 4'b0010,
		LNK_SHIFT = 4'b0100,
		LNK_DONE  = 4'b1000
	} ssy_link_state_type;

endpackage

`default_nettype wire

// *** ssy_peer.sv ***
// Purpose: Far-side serial master or slave facing the port.
// Assumes: The bench resolves every line from all drivers.
// Notes:   When leading, a half bit period is four clk_i cycles.
`timescale 1ns/1ps
`default_nettype none

module ssy_peer (
	input  wire logic        clk_i,
	input  wire logic        master_i,
	input  wire logic        ssi_i,
	input  wire logic        cpol_i,
	input  wire logic [4:0]  nbits_i,
	input  wire logic [15:0] tx_i,
	input  wire logic        start_i,
	input  wire logic        sclk_i,
	input  wire logic        sel_i,
	input  wire logic        fwd_i,
	input  wire logic        ret_i,
	output logic             sclk_o,
	output logic             sel_o,
	output logic             fwd_o,
	output logic             ret_o,
	output logic             ret_en_o,
	output logic      [15:0] rx_o,
	output logic      [7:0]  frames_o
);
	logic [15:0] sh = 16'h0000;
	logic [15:0] acc = 16'h0000;
	logic [15:0] ms = 16'h0000;
	logic [15:0] mr = 16'h0000;
	logic [4:0]  cnt = 5'h00;
	logic        act = 1'b0;
	logic        busy = 1'b0;
	wire         lead = sclk_i ^ cpol_i;

	initial begin
		rx_o = 16'h0000;
		frames_o = 8'h00;
	end

	assign ret_o = sh[nbits_i - 5'h01];
	// Only a selected slave may drive the shared return line
	assign ret_en_o = act && !master_i && (ssi_i || !sel_i);

	task automatic load();
		sh = tx_i;
		acc = 16'h0000;
		cnt = 5'h00;
	endtask

	task automatic half();
		repeat (4) @(posedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// Slave side
	// ----------------------------------------------------------------
	always @(posedge sel_i) begin
		if (!master_i) begin
			load();
			act = ssi_i;
		end
	end

	always @(negedge sel_i) begin
		if (!master_i && !ssi_i) begin
			load();
			act = 1'b1;
		end
	end

	always @(posedge lead) begin
		if (act && !master_i) begin
			acc = {acc[14:0], fwd_i};
			cnt = cnt + 5'h01;
			if (cnt == nbits_i) begin
				rx_o = acc;
				frames_o = frames_o + 8'h01;
				act = 1'b0;
			end
		end
	end

	always @(negedge lead) begin
		if (act && !master_i)
			sh = sh << 1;
	end

	// ----------------------------------------------------------------
	// Master side
	// ----------------------------------------------------------------
	always @(master_i or ssi_i or cpol_i) begin
		if (!busy) begin
			sel_o <= !ssi_i;
			sclk_o <= cpol_i;
			fwd_o <= 1'b0;
		end
	end

	always begin
		@(posedge start_i);
		busy = 1'b1;
		ms = tx_i;
		mr = 16'h0000;
		sel_o <= ssi_i;
		fwd_o <= tx_i[nbits_i - 5'h01];
		half();
		if (ssi_i)
			sel_o <= 1'b0;
		for (int i = 0; i < nbits_i; i++) begin
			half();
			sclk_o <= ~cpol_i;
			mr = {mr[14:0], ret_i};
			half();
			sclk_o <= cpol_i;
			ms = ms << 1;
			fwd_o <= ms[nbits_i - 5'h01];
		end
		half();
		sel_o <= !ssi_i;
		rx_o = mr;
		frames_o = frames_o + 8'h01;
		busy = 1'b0;
	end
endmodule

`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the serial port.
// Assumes: Far side is ssy_peer; select pulls up, clock pulls down.
// Notes:   Released data lines show the inverse of their last level.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        core_clk = 1'b0, link_clk = 1'b0, reset = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic        pready, pslverr, peer_master = 1'b0, cfg_en = 1'b0;
	logic        cfg_slave = 1'b0, cfg_ssi = 1'b0, cfg_cpol = 1'b0;
	logic        ret_last = 1'b0, fwd_last = 1'b0;
	logic        sclk_o, sclk_oe_n, sel_o, sel_oe_n, ret_o, ret_oe_n;
	logic        fwd_o, fwd_oe_n, p_sclk, p_sel, p_fwd, p_ret, p_ret_en;
	logic [4:0]  cfg_n = 5'h08;
	logic [15:0] peer_tx = 16'h5A3C, p_rx;
	logic [7:0]  p_frames;
	int          fail_count = 0, compares = 0, sel_hi = 0;
	wire sclk_bus = !sclk_oe_n ? sclk_o : (peer_master ? p_sclk : 1'b0);
	wire sel_bus = !sel_oe_n ? sel_o : (peer_master ? p_sel : 1'b1);
	wire fwd_bus = !fwd_oe_n ? fwd_o : (peer_master ? p_fwd : ~fwd_last);
	wire ret_bus = !ret_oe_n ? ret_o : (p_ret_en ? p_ret : ~ret_last);

	ssy_port i_dut (
		.core_clk_i(core_clk), .reset_i(reset), .link_clk_i(link_clk),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr),
		.serial_clock_pin_i(sclk_bus), .serial_clock_pin_o(sclk_o),
		.serial_clock_pin_oe_n_o(sclk_oe_n),
		.select_framesync_pin_i(sel_bus), .select_framesync_pin_o(sel_o),
		.select_framesync_pin_oe_n_o(sel_oe_n),
		.slave_to_master_data_pin_i(ret_bus),
		.slave_to_master_data_pin_o(ret_o),
		.slave_to_master_data_pin_oe_n_o(ret_oe_n),
		.master_to_slave_data_pin_i(fwd_bus),
		.master_to_slave_data_pin_o(fwd_o),
		.master_to_slave_data_pin_oe_n_o(fwd_oe_n)
	);

	ssy_peer i_peer (
		.clk_i(core_clk), .master_i(peer_master), .ssi_i(cfg_ssi),
		.cpol_i(cfg_cpol), .nbits_i(cfg_n), .tx_i(peer_tx), .start_i(start),
		.sclk_i(sclk_bus), .sel_i(sel_bus), .fwd_i(fwd_bus), .ret_i(ret_bus),
		.sclk_o(p_sclk), .sel_o(p_sel), .fwd_o(p_fwd), .ret_o(p_ret),
		.ret_en_o(p_ret_en), .rx_o(p_rx), .frames_o(p_frames)
	);

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	initial begin
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	// ----------------------------------------------------------------
	// Pin watch
	// ----------------------------------------------------------------
	// Select passes two flops inside, so allow a few cycles of lag
	always @(posedge link_clk) begin
		ret_last <= ret_bus;
		fwd_last <= fwd_bus;
		sel_hi <= sel_bus ? sel_hi + 1 : 0;
		if (cfg_en && cfg_slave && !(sclk_oe_n && fwd_oe_n))
			chk("slave_master_pins", 32'h0000_0000, 32'h0000_0001);
		if (cfg_en && !cfg_slave && !ret_oe_n)
			chk("master_return_pin", 32'h0000_0000, 32'h0000_0001);
		if (cfg_en && cfg_slave && !cfg_ssi && sel_hi > 4 && !ret_oe_n)
			chk("unselected_return", 32'h0000_0001, 32'h0000_0000);
		if (cfg_en && !cfg_slave && !cfg_ssi && sel_hi > 4 && !sclk_oe_n)
			chk("idle_clock", {31'h0, cfg_cpol}, {31'h0, sclk_bus});
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (fail_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk("pready_wait", 32'h0000_0001, 32'h0000_0000);
			end_sim();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk("write_error", 32'h0000_0000, {31'h0, e});
	endtask

	task automatic rd(input string what, input logic [11:0] a,
			input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(what, exp, r);
	endtask

	task automatic cfg(input logic en, input logic sl, input logic [1:0] f,
			input logic cp, input logic [4:0] n);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[3:0] = 4'(n - 5'h01);
		v[5:4] = f;
		v[ssy_pkg::CTRL_CPOL] = cp;
		v[ssy_pkg::CTRL_SLAVE] = sl;
		cfg_en = 1'b0;
		wr(ssy_pkg::ADDR_CTRL, v);
		cfg_slave = sl;
		cfg_ssi = (f == ssy_pkg::FMT_SSI);
		cfg_cpol = cp;
		cfg_n = n;
		peer_master = sl;
		v[ssy_pkg::CTRL_EN] = en;
		wr(ssy_pkg::ADDR_CTRL, v);
		cfg_en = en;
	endtask

	task automatic wait_frames(input logic [7:0] t);
		int n;
		n = 0;
		while (p_frames !== t && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 4000) begin
			chk("frame_wait", 32'h0000_0001, 32'h0000_0000);
			end_sim();
		end
		repeat (20) @(posedge core_clk);
	endtask

	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		rd("ctrl_reset", ssy_pkg::ADDR_CTRL, {22'h00_0000, ssy_pkg::CTRL_RESET});
		rd("div_reset", ssy_pkg::ADDR_DIV, {24'h00_0000, ssy_pkg::DIV_RESET});
		rd("stat_reset", ssy_pkg::ADDR_STAT, 32'h0000_0003);
		chk("pins_released", 32'h0000_000F,
			{28'h0, sclk_oe_n, sel_oe_n, ret_oe_n, fwd_oe_n});
		apb(1'b0, 12'h010, 32'h0000_0000, r, e);
		chk("unmapped_error", 32'h0000_0001, {31'h0, e});
	endtask

	// Two words back to back; both frames must appear on the wire
	task automatic t_master(input logic [1:0] f, input logic cp,
			input logic [4:0] n, input logic [15:0] a, input logic [15:0] b);
		logic [15:0] m;
		logic [7:0]  f0;
		m = 16'hFFFF >> (5'h10 - n);
		f0 = p_frames;
		cfg(1'b1, 1'b0, f, cp, n);
		wr(ssy_pkg::ADDR_DATA, {16'h0000, a});
		wr(ssy_pkg::ADDR_DATA, {16'h0000, b});
		wait_frames(f0 + 8'h02);
		chk("peer_rx", {16'h0000, b & m}, {16'h0000, p_rx & m});
		rd("rx_first", ssy_pkg::ADDR_DATA, {16'h0000, peer_tx & m});
		rd("rx_second", ssy_pkg::ADDR_DATA, {16'h0000, peer_tx & m});
		rd("stat_drained", ssy_pkg::ADDR_STAT, 32'h0000_0003);
	endtask

	task automatic t_buffer();
		logic [7:0] f0;
		f0 = p_frames;
		cfg(1'b0, 1'b0, ssy_pkg::FMT_SPI, 1'b0, 5'h08);
		wr(ssy_pkg::ADDR_DIV, 32'h0000_0002);
		rd("div_write", ssy_pkg::ADDR_DIV, 32'h0000_0002);
		for (int i = 0; i < 9; i++)
			wr(ssy_pkg::ADDR_DATA, 32'h0000_0010 + 32'(i));
		rd("stat_tx_full", ssy_pkg::ADDR_STAT, 32'h0000_0000);
		cfg(1'b1, 1'b0, ssy_pkg::FMT_SPI, 1'b0, 5'h08);
		wait_frames(f0 + 8'h08);
		rd("stat_rx_full", ssy_pkg::ADDR_STAT, 32'h0000_000F);
		chk("last_sent", 32'h0000_0017, {24'h0, p_rx[7:0]});
		// A frame into a full receive buffer is dropped and flagged
		wr(ssy_pkg::ADDR_DATA, 32'h0000_0019);
		wait_frames(f0 + 8'h09);
		rd("stat_overrun", ssy_pkg::ADDR_STAT, 32'h0000_002F);
		chk("extra_sent", 32'h0000_0019, {24'h0, p_rx[7:0]});
		wr(ssy_pkg::ADDR_STAT, 32'h0000_0020);
		rd("stat_ovr_clear", ssy_pkg::ADDR_STAT, 32'h0000_000F);
		for (int i = 0; i < 8; i++)
			rd("rx_word", ssy_pkg::ADDR_DATA, {24'h0, peer_tx[7:0]});
		rd("stat_empty", ssy_pkg::ADDR_STAT, 32'h0000_0003);
	endtask

	task automatic t_slave(input logic [1:0] f);
		logic [7:0] f0;
		f0 = p_frames;
		cfg(1'b1, 1'b1, f, 1'b0, 5'h08);
		wr(ssy_pkg::ADDR_DATA, 32'h0000_00C6);
		// Let the word reach the link side before the frame starts
		repeat (8) @(posedge core_clk);
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		wait_frames(f0 + 8'h01);
		chk("master_rx", 32'h0000_00C6, {24'h0, p_rx[7:0]});
		rd("slave_rx", ssy_pkg::ADDR_DATA, {24'h0, peer_tx[7:0]});
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		repeat (8) @(posedge core_clk);
		t_reset();
		t_master(ssy_pkg::FMT_SPI, 1'b0, 5'h08, 16'h00A1, 16'h005E);
		t_master(ssy_pkg::FMT_SPI, 1'b1, 5'h10, 16'h1234, 16'hBEEF);
		t_master(ssy_pkg::FMT_SPI, 1'b0, 5'h04, 16'h0009, 16'h0006);
		t_master(ssy_pkg::FMT_SSI, 1'b0, 5'h0C, 16'h0ACE, 16'h0531);
		t_master(ssy_pkg::FMT_MWIRE, 1'b0, 5'h08, 16'h003C, 16'h00C3);
		t_buffer();
		t_slave(ssy_pkg::FMT_SPI);
		t_slave(ssy_pkg::FMT_SSI);
		end_sim();
	end
endmodule

`default_nettype wire
